//--- design/simd_add_defs.vh
/*
   Constants of the unsigned packed add unit: register offsets,
   instruction and status field positions, codes and reset values.
   Assumes inclusion by the unit's sources and by its bench.
*/
`ifndef SIMD_ADD_DEFS_VH
`define SIMD_ADD_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_INSTR      12'h000
`define OFS_STATUS     12'h004
`define OFS_INFO       12'h008
`define OFS_GPR_FIRST  12'h040
`define OFS_GPR_LAST   12'h07c

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define F_COND   31:28
`define F_GROUP  27:20
`define F_FIRST  19:16
`define F_DEST   15:12
`define F_SUB    7:4
`define F_SECOND 3:0

`define GROUP_PLAIN  8'h65
`define GROUP_HALVE  8'h67
`define SUB_DUAL     4'h1
`define SUB_QUAD     4'h9
`define SUB_XCH      4'h3
`define COND_ALWAYS  4'he
`define COND_NEVER   4'hf

// ----------------------------------------
// Core operation codes
// ----------------------------------------
`define OP_DUAL      3'h0
`define OP_QUAD      3'h1
`define OP_XCH       3'h2
`define OP_DUAL_HALF 3'h3
`define OP_QUAD_HALF 3'h4

// ----------------------------------------
// Status word and info fields, resets
// ----------------------------------------
`define F_NZCV        31:28
`define F_GE          19:16
`define STATUS_WMASK  32'hf00f0000
`define STATUS_RESET  32'h00000000
`define INSTR_RESET   32'h00000000
`define GPR_RESET     32'h00000000
`define INFO_DONE     0
`define INFO_SKIP     1
`define INFO_UNDEC    2
`define F_INFO_COUNT  31:16

`endif

//--- design/simd_add_core.v
/*
   Combinational unsigned packed add datapath.
   Assumes operands come from the register file and the result
   and flag update are committed by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "simd_add_defs.vh"

module simd_add_core (
   // Operation select
   input  wire [2:0]  op_sel,
   // Operands
   input  wire [31:0] first_val,
   input  wire [31:0] second_val,
   // Results
   output reg  [31:0] result,
   output reg  [3:0]  ge_value,
   output reg         ge_update
);

   function [16:0] add17;
      input [15:0] x;
      input [15:0] y;
      add17 = {1'b0, x} + {1'b0, y};
   endfunction

   function [8:0] add9;
      input [7:0] x;
      input [7:0] y;
      add9 = {1'b0, x} + {1'b0, y};
   endfunction

   wire [16:0] sum_lo = add17(first_val[15:0], second_val[15:0]);
   wire [16:0] sum_hi = add17(first_val[31:16], second_val[31:16]);
   wire [8:0]  sum_b0 = add9(first_val[7:0], second_val[7:0]);
   wire [8:0]  sum_b1 = add9(first_val[15:8], second_val[15:8]);
   wire [8:0]  sum_b2 = add9(first_val[23:16], second_val[23:16]);
   wire [8:0]  sum_b3 = add9(first_val[31:24], second_val[31:24]);
   // Second operand halves swapped
   wire [16:0] xch_sum = add17(first_val[31:16], second_val[15:0]);
   wire [16:0] xch_diff = {1'b0, first_val[15:0]}
                        - {1'b0, second_val[31:16]};

   always @* begin
      result    = 32'h00000000;
      ge_value  = 4'h0;
      ge_update = 1'b0;
      case (op_sel)
         `OP_DUAL: begin
            result    = {sum_hi[15:0], sum_lo[15:0]};
            ge_value  = {{2{sum_hi[16]}}, {2{sum_lo[16]}}};
            ge_update = 1'b1;
         end
         `OP_QUAD: begin
            result    = {sum_b3[7:0], sum_b2[7:0],
                         sum_b1[7:0], sum_b0[7:0]};
            ge_value  = {sum_b3[8], sum_b2[8],
                         sum_b1[8], sum_b0[8]};
            ge_update = 1'b1;
         end
         `OP_XCH: begin
            result    = {xch_sum[15:0], xch_diff[15:0]};
            // Borrow is the wrap of the 17-bit difference
            ge_value  = {{2{xch_sum[16]}}, {2{xch_diff[16]}}};
            ge_update = 1'b1;
         end
         `OP_DUAL_HALF: begin
            result    = {sum_hi[16:1], sum_lo[16:1]};
            ge_update = 1'b0;
         end
         `OP_QUAD_HALF: begin
            result    = {sum_b3[8:1], sum_b2[8:1],
                         sum_b1[8:1], sum_b0[8:1]};
            ge_update = 1'b0;
         end
         default: begin
            result    = 32'h00000000;
            ge_update = 1'b0;
         end
      endcase
   end

endmodule // simd_add_core
`default_nettype wire

//--- design/simd_add_unit.v
/*
   Unsigned packed add unit behind an APB slave. Holds a sixteen
   word register file, an instruction register whose write runs
   one instruction, a status word with condition and greater-equal
   flags, and a read-only execution info register.
   Assumes an APB master on pclk; one access at a time.
   Assumes software keeps the program counter index out of
   exchange instructions; such a result is simply the datapath's.
*/
`timescale 1ns/100ps
`default_nettype none
`include "simd_add_defs.vh"

module simd_add_unit (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB request
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   // APB answer
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Flag view
   output wire [3:0]  greater_equal_flags
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function [31:0] merge_bytes;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  lanes;
      integer i;
      begin
         merge_bytes = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (lanes[i]) begin
               merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
            end
         end
      end
   endfunction

   function cond_pass;
      input [3:0] cond;
      input [3:0] nzcv;
      reg n;
      reg z;
      reg c;
      reg v;
      begin
         n = nzcv[3];
         z = nzcv[2];
         c = nzcv[1];
         v = nzcv[0];
         case (cond)
            4'h0:    cond_pass = z;
            4'h1:    cond_pass = ~z;
            4'h2:    cond_pass = c;
            4'h3:    cond_pass = ~c;
            4'h4:    cond_pass = n;
            4'h5:    cond_pass = ~n;
            4'h6:    cond_pass = v;
            4'h7:    cond_pass = ~v;
            4'h8:    cond_pass = c & ~z;
            4'h9:    cond_pass = ~c | z;
            4'ha:    cond_pass = (n == v);
            4'hb:    cond_pass = (n != v);
            4'hc:    cond_pass = ~z & (n == v);
            4'hd:    cond_pass = z | (n != v);
            `COND_ALWAYS: cond_pass = 1'b1;
            // Unconditional space is not this unit's
            default: cond_pass = 1'b0;
         endcase
      end
   endfunction

   function is_gpr;
      input [11:0] addr;
      begin
         is_gpr = (addr >= `OFS_GPR_FIRST) &&
                  (addr <= `OFS_GPR_LAST);
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg  [31:0] gpr_mem [0:15];
   reg  [31:0] instr_reg;
   reg  [31:0] status_reg;
   reg  [31:0] info_reg;
   reg         ack_reg;
   reg  [31:0] rdata_next;

   integer k;

   // ----------------------------------------
   // APB handshake
   // ----------------------------------------
   // One wait state so read data can come from a flop
   wire access     = psel & penable;
   wire first_beat = access & ~ack_reg;
   wire commit     = access & ack_reg;
   wire aligned    = (paddr[1:0] == 2'b00);

   wire hit_instr  = (paddr == `OFS_INSTR);
   wire hit_status = (paddr == `OFS_STATUS);
   wire hit_info   = (paddr == `OFS_INFO);
   wire hit_gpr    = aligned & is_gpr(paddr);
   wire mapped     = hit_instr | hit_status | hit_info | hit_gpr;

   wire [3:0] gpr_index = paddr[5:2];

   assign pready  = commit;
   assign pslverr = commit & ~mapped;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= first_beat;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always @* begin
      rdata_next = 32'h00000000;
      if (hit_instr) begin
         rdata_next = instr_reg;
      end else if (hit_status) begin
         rdata_next = status_reg;
      end else if (hit_info) begin
         rdata_next = info_reg;
      end else if (hit_gpr) begin
         rdata_next = gpr_mem[gpr_index];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (first_beat && !pwrite) begin
         prdata <= rdata_next;
      end
   end

   // ----------------------------------------
   // Write enables
   // ----------------------------------------
   // Every write lands at the edge that ends the access
   wire        wr_commit = commit & pwrite;
   wire        run       = wr_commit & hit_instr;
   wire        wr_status = wr_commit & hit_status;
   wire        wr_gpr    = wr_commit & hit_gpr;

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   // Decode sees the merged word, not the old register
   wire [31:0] instr_in  = merge_bytes(instr_reg, pwdata, pstrb);

   // Bits 11:8 take no part in decode
   wire [7:0] group_f = instr_in[`F_GROUP];
   wire [3:0] sub_f   = instr_in[`F_SUB];

   wire [3:0] first_src_field  = instr_in[`F_FIRST];
   wire [3:0] second_src_field = instr_in[`F_SECOND];
   wire [3:0] dest_field       = instr_in[`F_DEST];

   wire       op_plain = (group_f == `GROUP_PLAIN);
   wire       op_halve = (group_f == `GROUP_HALVE);

   reg  [2:0] op_sel;
   reg        op_known;

   always @* begin
      op_sel   = `OP_DUAL;
      op_known = 1'b0;
      if (op_plain) begin
         case (sub_f)
            `SUB_DUAL: begin
               op_sel   = `OP_DUAL;
               op_known = 1'b1;
            end
            `SUB_QUAD: begin
               op_sel   = `OP_QUAD;
               op_known = 1'b1;
            end
            `SUB_XCH: begin
               op_sel   = `OP_XCH;
               op_known = 1'b1;
            end
            default: begin
               op_known = 1'b0;
            end
         endcase
      end else if (op_halve) begin
         case (sub_f)
            `SUB_DUAL: begin
               op_sel   = `OP_DUAL_HALF;
               op_known = 1'b1;
            end
            `SUB_QUAD: begin
               op_sel   = `OP_QUAD_HALF;
               op_known = 1'b1;
            end
            // Halving exchange is outside this unit
            default: begin
               op_known = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Condition check
   // ----------------------------------------
   // Flags as they stood before this instruction
   wire [3:0] cond_f = instr_in[`F_COND];
   wire [3:0] nzcv_f = status_reg[`F_NZCV];
   wire       passed = cond_pass(cond_f, nzcv_f);

   // Program counter index gets no special care here
   wire do_exec = run & op_known & passed;

   // ----------------------------------------
   // Datapath
   // ----------------------------------------
   wire [31:0] result;
   wire [3:0]  ge_value;
   wire        ge_update;

   simd_add_core u_core (
      .op_sel     (op_sel),
      .first_val  (gpr_mem[first_src_field]),
      .second_val (gpr_mem[second_src_field]),
      .result     (result),
      .ge_value   (ge_value),
      .ge_update  (ge_update)
   );

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------
   reg  [31:0] instr_next;

   always @* begin
      instr_next = instr_reg;
      if (run) begin
         instr_next = instr_in;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_reg <= `INSTR_RESET;
      end else begin
         instr_reg <= instr_next;
      end
   end

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   wire [31:0] gpr_wr = merge_bytes(gpr_mem[gpr_index], pwdata, pstrb);

   // An instruction write and a bus write never coincide
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (k = 0; k < 16; k = k + 1) begin
            gpr_mem[k] <= `GPR_RESET;
         end
      end else if (do_exec) begin
         gpr_mem[dest_field] <= result;
      end else if (wr_gpr) begin
         gpr_mem[gpr_index] <= gpr_wr;
      end
   end

   // ----------------------------------------
   // Status word
   // ----------------------------------------
   wire [31:0] status_wr = merge_bytes(status_reg, pwdata, pstrb)
                         & `STATUS_WMASK;

   // Halving adds drop ge_update, so the flags keep their value
   wire        ge_write = do_exec & ge_update;
   reg  [31:0] status_next;

   always @* begin
      status_next = status_reg;
      if (ge_write) begin
         status_next[`F_GE] = ge_value;
      end else if (wr_status) begin
         status_next = status_wr;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= `STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   assign greater_equal_flags = status_reg[`F_GE];

   // ----------------------------------------
   // Execution info
   // ----------------------------------------
   // Count wraps; software takes differences
   // Flag bits describe the last instruction only
   reg  [31:0] info_next;

   always @* begin
      info_next = info_reg;
      if (run) begin
         info_next[`INFO_DONE]  = do_exec;
         info_next[`INFO_SKIP]  = op_known & ~passed;
         info_next[`INFO_UNDEC] = ~op_known;
         if (do_exec) begin
            info_next[`F_INFO_COUNT] =
               info_reg[`F_INFO_COUNT] + 16'h0001;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         info_reg <= 32'h00000000;
      end else begin
         info_reg <= info_next;
      end
   end

endmodule // simd_add_unit
`default_nettype wire

//--- tb/simd_add_checks_props.sv
/*
   Checker for bus timing and flag updates of the packed add unit.
   Assumes a bind to simd_add_unit, one pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module simd_add_checks (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Bus
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Flags
   input wire logic [3:0]  greater_equal_flags
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic done_w = psel & penable & pready & pwrite;
   property p_one_wait;
      psel && $rose(penable) |-> !pready ##1 pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_err_pair;
      pslverr |-> pready;
   endproperty
   property p_unmapped;
      psel && pready && paddr inside {[12'h00c:12'h03c]} |-> pslverr;
   endproperty
   property p_read_hold;
      !(psel && penable && !pwrite) |=> $stable(prdata);
   endproperty
   property p_flags_cause;
      !done_w |=> $stable(greater_equal_flags);
   endproperty
   property p_never_keeps;
      done_w && paddr == 12'h000 && pwdata[31:28] == 4'hf
         |=> $stable(greater_equal_flags);
   endproperty
   property p_halving_keeps;
      done_w && paddr == 12'h000 && pwdata[27:20] == 8'h67
         |=> $stable(greater_equal_flags);
   endproperty
   property p_status_sets;
      done_w && paddr == 12'h004 && pstrb[2]
         |=> greater_equal_flags == $past(pwdata[19:16]);
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("ready not after one wait");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   a_err_pair: assert property (p_err_pair)
      else $error("error without ready");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access without error");
   a_read_hold: assert property (p_read_hold)
      else $error("read data moved outside a read");
   a_flags_cause: assert property (p_flags_cause)
      else $error("flags moved without a write");
   a_never_keeps: assert property (p_never_keeps)
      else $error("failed condition changed flags");
   a_halving_keeps: assert property (p_halving_keeps)
      else $error("halving add changed flags");
   a_status_sets: assert property (p_status_sets)
      else $error("status write lost flags");
   c_halving: cover property (done_w && pwdata[27:20] == 8'h67);
   c_plain: cover property (done_w && pwdata[27:20] == 8'h65);
   c_error: cover property (pslverr);
endmodule // simd_add_checks
`default_nettype wire

//--- tb/apb_host_model.sv
/*
   Bus master standing in for the instruction side of the core.
   Assumes one transfer at a time, started from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module apb_host_model (
   // Clock
   input wire logic        pclk,
   // Request
   output var logic [11:0] paddr,
   output var logic        psel,
   output var logic        penable,
   output var logic        pwrite,
   output var logic [31:0] pwdata,
   output var logic [3:0]  pstrb,
   // Answer
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   initial begin
      {paddr, psel, penable, pwrite, pwdata, pstrb} = '0;
   end
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale data must not look valid
      pwdata <= ~d;
   endtask
endmodule // apb_host_model
`default_nettype wire

//--- tb/simd_add_unit_bench.sv
/*
   Self-checking bench of the packed add unit with random operands.
   Assumes the unit's defines header on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "simd_add_defs.vh"
module simd_add_unit_bench;
   logic        pclk;
   logic        presetn;
   wire  [11:0] paddr;
   wire         psel, penable, pwrite, pready, pslverr;
   wire  [31:0] pwdata, prdata;
   wire  [3:0]  pstrb, greater_equal_flags;
   int          mismatches, comparisons, i, k, execs;
   logic [31:0] seed, q, va, vb, ins, regs [16];
   logic [35:0] p;
   logic [3:0]  fa, fb, fd, flg, cnd;
   logic        e, pass;
   logic [3:0]  subs [5] = '{`SUB_DUAL, `SUB_QUAD, `SUB_XCH,
                             `SUB_DUAL, `SUB_QUAD};
   simd_add_unit simd_add_unit_i (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .greater_equal_flags(greater_equal_flags));
   apb_host_model apb_host_model_i (.pclk(pclk), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   function logic [31:0] next_rand();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic logic [35:0] predict(int k, logic [31:0] a, b,
                                           logic [3:0] f);
      logic [16:0] lo, hi;
      logic [8:0]  s;
      logic [35:0] r;
      lo = a[15:0] + b[15:0];
      hi = a[31:16] + b[31:16];
      r = {{2{hi[16]}}, {2{lo[16]}}, hi[15:0], lo[15:0]};
      if (k == 3) r = {f, hi[16:1], lo[16:1]};
      if (k == 2) begin
         hi = a[31:16] + b[15:0];
         lo = a[15:0] - b[31:16];
         r = {{2{hi[16]}}, {2{a[15:0] < b[31:16]}}, hi[15:0], lo[15:0]};
      end
      for (int n = 0; n < 4 && (k == 1 || k == 4); n++) begin
         s = a[8*n +: 8] + b[8*n +: 8];
         r[32+n] = (k == 1) ? s[8] : f[n];
         r[8*n +: 8] = (k == 1) ? s[7:0] : s[8:1];
      end
      return r;
   endfunction
   task chk_word(string n, logic [31:0] x, g);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task chk_flag(string n, logic [3:0] x, g);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
      apb_host_model_i.xfer(1'b1, a, d, s, q, e);
   endtask
   task print_verdict();
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      print_verdict();
   end
   initial begin
      presetn = 1'b0;
      seed = 32'd94944;
      flg = 4'h0;
      execs = 0;
      // Register file model starts at its reset value
      regs = '{default: `GPR_RESET};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb_host_model_i.xfer(1'b0, `OFS_STATUS, 32'h0, 4'hf, q, e);
      chk_word("status reset", 32'h0, q);
      apb_host_model_i.xfer(1'b0, 12'h010, 32'h0, 4'hf, q, e);
      chk_word("unmapped error", 32'h1, {31'h0, e});
      // Lane 2 strobe off, flags must not move
      wr(`OFS_STATUS, 32'h000f0000, 4'h8);
      apb_host_model_i.xfer(1'b0, `OFS_STATUS, 32'h0, 4'hf, q, e);
      chk_flag("masked flags", 4'h0, greater_equal_flags);
      chk_word("masked status", 32'h0, q);
      // Lane 2 only; bits outside the flag fields read zero
      wr(`OFS_STATUS, 32'h00fa0000, 4'h4);
      flg = 4'ha;
      apb_host_model_i.xfer(1'b0, `OFS_STATUS, 32'h0, 4'hf, q, e);
      chk_flag("written flags", flg, greater_equal_flags);
      chk_word("written status", 32'h000a0000, q);
      for (i = 0; i < 60; i++) begin
         k = i % 5;
         {fa, fb, fd} = next_rand();
         if (k == 2 && fa == 4'hf) fa = 4'he;
         if (k == 2 && fb == 4'hf) fb = 4'he;
         if (k == 2 && fd == 4'hf) fd = 4'he;
         // Early passes force every lane carry, then none
         va = (i < 5) ? 32'hffffffff : (i < 10) ? 32'h0 : next_rand();
         vb = (i < 5) ? 32'hffffffff : next_rand();
         wr(`OFS_GPR_FIRST + {6'h0, fa, 2'b00}, va, 4'hf);
         regs[fa] = va;
         wr(`OFS_GPR_FIRST + {6'h0, fb, 2'b00}, vb, 4'hf);
         regs[fb] = vb;
         // Status NZCV stays clear: equal fails, not-equal passes
         cnd = (i % 7 == 6) ? `COND_NEVER : (i % 7 == 5) ? 4'h0 :
               (i % 7 == 4) ? 4'h1 : `COND_ALWAYS;
         pass = (cnd == `COND_ALWAYS) || (cnd == 4'h1);
         va = next_rand();
         ins = {cnd, (k > 2) ? `GROUP_HALVE : `GROUP_PLAIN, fa, fd,
                va[11:8], subs[k], fb};
         p = predict(k, regs[fa], regs[fb], flg);
         wr(`OFS_INSTR, ins, 4'hf);
         if (pass) begin
            regs[fd] = p[31:0];
            flg = p[35:32];
            execs++;
         end
         apb_host_model_i.xfer(1'b0, `OFS_GPR_FIRST + {6'h0, fd, 2'b00},
                               32'h0, 4'hf, q, e);
         chk_word("result", regs[fd], q);
         chk_flag("flags", flg, greater_equal_flags);
      end
      // Halving exchange is left undecoded: only the instruction register and the info flag bits may change
      wr(`OFS_INSTR, {`COND_ALWAYS, `GROUP_HALVE, fa, fd, 4'h0,
                      `SUB_XCH, fb}, 4'hf);
      apb_host_model_i.xfer(1'b0, `OFS_INFO, 32'h0, 4'hf, q, e);
      chk_word("info", {execs[15:0], 16'h0004}, q);
      apb_host_model_i.xfer(1'b0, `OFS_GPR_FIRST + {6'h0, fd, 2'b00},
                            32'h0, 4'hf, q, e);
      chk_word("kept result", regs[fd], q);
      chk_flag("kept flags", flg, greater_equal_flags);
      print_verdict();
   end
endmodule // simd_add_unit_bench
bind simd_add_unit simd_add_checks simd_add_checks_i (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .greater_equal_flags(greater_equal_flags));
`default_nettype wire
